// [core/scg_pkg.sv]
// Constants and carrier types for the system clock gear and timing block
// Notes on behaviour
// (R01) Gear clock muxed from four fast clock divisions
// (R02) Gear taps come from three-stage prescaler
// (R03) Gear defaults to divide-by-eight after reset
// (R04) Two-stage prescaler feeds twenty-one stage divider
// (R05) Provides main clock, divider taps, warm-up clock
// (R06) Divider taps independent of gear setting
// (R07) Speed field bits 7:5 selects low-speed taps
// (R08) Tap availability follows speed code and gear
// (R09) Software sets speed field once, before use
// (R10) Prescaler and divider cleared on reset, stop
// (R11) Seventh stage input follows mode and select
// (R12) Never select low clock in single mode; the slow bit still selects it with dual bit clear
// (R13) Slow modes stop divider stages one to six
// (R14) Machine cycle is four main clock states
// (R15) Instructions last one to ten machine cycles
// (R16) Main clock from gear, or low clock slow
// (R17) Stages halve; gear switches with clocks low
// (R18) Speed field and gear reset to defaults
package scg_pkg;
    // Register byte offsets
    localparam logic [7:0] GEAR_CTRL_OFF = 8'h00;
    localparam logic [7:0] TBASE_CTRL_OFF = 8'h04;
    localparam logic [7:0] MODE_CTRL_OFF = 8'h08;
    localparam logic [7:0] STATUS_OFF = 8'h0c;
    // Field positions
    localparam int DVS_LSB = 5;
    localparam int GEAR_LSB = 0;
    localparam int SEVEN_BIT = 4;
    localparam int MODE_DUAL_BIT = 0;
    localparam int MODE_SLOW_BIT = 1;
    localparam int MODE_STOP_BIT = 2;
    localparam int ST_GEAR_LSB = 0;
    localparam int ST_STATE_LSB = 2;
    localparam int ST_INDEX_LSB = 4;
    localparam int ST_TAP_LSB = 8;
    // Reset values
    localparam logic [1:0] GEAR_RST = 2'h3;
    localparam logic [2:0] DVS_RST = 3'h0;
    // Structure sizes and counts
    localparam int DIV_STAGES = 21;
    localparam int LOW_STAGES = 6;
    localparam logic [2:0] GEAR_WRAP = 3'h7;
    localparam logic [1:0] PRE_WRAP = 2'h3;
    localparam logic [1:0] LAST_STATE = 2'h3;
    localparam logic [3:0] MAX_CYCLES = 4'ha;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Bus request from master
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } scg_axi_req_t;
    // Bus answer from slave
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } scg_axi_rsp_t;
endpackage

// [core/scg_gear.sv]
// Clock gear: three-stage prescaler and glitch-free gear select
`timescale 1ns/1ps
module scg_gear import scg_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Gear request and result
    input wire logic [1:0] gear_req,
    output logic gear_tick,
    output logic [1:0] gear_cur
);
    logic [2:0] presc_ff;
    logic [1:0] sel_ff;

    // Rising point of the selected gear clock
    function automatic logic gear_edge(input logic [1:0] sel, input logic [2:0] p);
        case (sel)
            2'h0: gear_edge = 1'b1;
            2'h1: gear_edge = p[0];
            2'h2: gear_edge = &p[1:0];
            default: gear_edge = &p;
        endcase
    endfunction

    // (R02) three cascaded halving stages
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_ff <= 3'h0;
        end else begin
            presc_ff <= presc_ff + 3'h1;
        end
    end

    // (R03) (R17) reset to eighth; switch where taps low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ff <= GEAR_RST;
        end else if (presc_ff == GEAR_WRAP) begin
            sel_ff <= gear_req;
        end
    end

    // (R01) multiplexer over four sources
    assign gear_tick = gear_edge(sel_ff, presc_ff);
    assign gear_cur = sel_ff;

    a_gear_switch: assert property (@(posedge aclk) disable iff (!aresetn) // R17
        $changed(sel_ff) |-> $past(presc_ff) == GEAR_WRAP)
        else $error("gear changed outside wrap point");
    a_gear_default: assert property (@(posedge aclk) // R03
        $rose(aresetn) |-> sel_ff == GEAR_RST)
        else $error("gear not eighth after reset");
endmodule

// [core/scg_mcycle.sv]
// Machine cycle state and instruction cycle counters
`timescale 1ns/1ps
module scg_mcycle import scg_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Main clock tick and instruction length
    input wire logic main_tick,
    input wire logic [3:0] instr_len,
    // Counters
    output logic [1:0] state_ff,
    output logic [3:0] index_ff,
    output logic instr_end_ff
);
    logic [3:0] len_eff;
    logic last;

    // Clamp length to one through ten cycles
    always_comb begin
        len_eff = instr_len;
        if (instr_len == 4'h0) begin
            len_eff = 4'h1;
        end else if (instr_len > MAX_CYCLES) begin
            len_eff = MAX_CYCLES;
        end
    end
    assign last = (index_ff + 4'h1) >= len_eff;

    // (R14) four states per machine cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= 2'h0;
        end else if (main_tick) begin
            state_ff <= state_ff + 2'h1;
        end
    end

    // (R15) count machine cycles of an instruction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            index_ff <= 4'h0;
            instr_end_ff <= 1'b0;
        end else begin
            instr_end_ff <= main_tick && state_ff == LAST_STATE && last;
            if (main_tick && state_ff == LAST_STATE) begin
                index_ff <= last ? 4'h0 : index_ff + 4'h1;
            end
        end
    end

    a_state_step: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        main_tick |=> state_ff == 2'($past(state_ff) + 2'h1))
        else $error("state did not advance on main clock");
    a_index_bound: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        index_ff < MAX_CYCLES)
        else $error("instruction ran past ten cycles");
endmodule

// [core/scg_system_clock_gear_timing.sv]
// System clock gear and timing generator with its register slave
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module scg_system_clock_gear_timing import scg_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input scg_axi_req_t axi_req,
    output scg_axi_rsp_t axi_rsp,
    // Pins from outside
    input wire logic low_freq_clock,
    input wire logic stop_release,
    // Instruction length from the core
    input wire logic [3:0] instr_len,
    // Main clock and machine cycle
    output logic main_system_clock,
    output logic [1:0] mc_state,
    output logic [3:0] mc_index,
    output logic instr_end,
    // Divider outputs
    output logic [DIV_STAGES-1:0] div_stages,
    output logic [3:0] div_taps,
    output logic [3:0] tap_usable,
    output logic divider_pulse_output
);
    // Bus state
    scg_axi_rsp_t rsp_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic w_strb0_ff;
    // Software state
    logic [2:0] divider_speed_sel_ff;
    logic [1:0] gear_req_ff;
    logic seventh_stage_sel_ff;
    logic dual_ff;
    logic system_clock_source_sel_ff;
    logic stop_ff;
    logic stop_d_ff;
    // Pin synchronisers
    logic lf_s1_ff;
    logic lf_s2_ff;
    logic lf_s3_ff;
    logic rel_s1_ff;
    logic rel_s2_ff;
    // Timing chain
    logic [1:0] pre_ff;
    logic [DIV_STAGES-1:0] div_ff;
    logic [3:0] taps_ff;
    logic [3:0] tap_ok_ff;
    logic main_ff;
    logic pulse_ff;
    // Combinational
    logic gear_tick;
    logic [1:0] gear_cur;
    logic lf_edge;
    logic clr;
    logic use_fs;
    logic low_run;
    logic seven_in;
    logic main_tick;
    logic do_write;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [3:0] nxt_taps;
    logic [1:0] shift;

    // Usable taps per speed code and gear
    function automatic logic [3:0] tap_avail(input logic [2:0] dvs, input logic [1:0] g);
        if (g == 2'h3) begin
            tap_avail = 4'h0;
        end else if (dvs == 3'h6) begin
            tap_avail = 4'hf;
        end else if (dvs == 3'h4) begin
            tap_avail = (g == 2'h2) ? 4'h8 : 4'hf;
        end else begin
            tap_avail = 4'he << g;
        end
    endfunction

    // Stage offset of the low-speed taps
    function automatic logic [1:0] tap_shift(input logic [2:0] dvs);
        case (dvs)
            3'h4: tap_shift = 2'h1;
            3'h6: tap_shift = 2'h2;
            default: tap_shift = 2'h0;
        endcase
    endfunction

    // Register map decode
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = a == GEAR_CTRL_OFF || a == TBASE_CTRL_OFF
            || a == MODE_CTRL_OFF || a == STATUS_OFF;
    endfunction

    // Gear and machine cycle helpers
    scg_gear u_gear (
        .aclk(aclk),
        .aresetn(aresetn),
        .gear_req(gear_req_ff),
        .gear_tick(gear_tick),
        .gear_cur(gear_cur)
    );

    scg_mcycle u_mcycle (
        .aclk(aclk),
        .aresetn(aresetn),
        .main_tick(main_ff),
        .instr_len(instr_len),
        .state_ff(mc_state),
        .index_ff(mc_index),
        .instr_end_ff(instr_end)
    );

    // Two-stage synchronisers for the pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lf_s1_ff <= 1'b0;
            lf_s2_ff <= 1'b0;
            lf_s3_ff <= 1'b0;
            rel_s1_ff <= 1'b0;
            rel_s2_ff <= 1'b0;
        end else begin
            lf_s1_ff <= low_freq_clock;
            lf_s2_ff <= lf_s1_ff;
            lf_s3_ff <= lf_s2_ff;
            rel_s1_ff <= stop_release;
            rel_s2_ff <= rel_s1_ff;
        end
    end
    assign lf_edge = lf_s2_ff && !lf_s3_ff;

    // Bus handshake
    assign do_write = aw_got_ff && w_got_ff && !rsp_ff.bvalid;
    assign wr_hit = reg_hit(aw_addr_ff) && aw_addr_ff != STATUS_OFF;
    assign rd_hit = reg_hit(axi_req.araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_ff <= '0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h00000000;
            w_strb0_ff <= 1'b0;
        end else begin
            rsp_ff.awready <= !aw_got_ff && !(axi_req.awvalid && rsp_ff.awready);
            rsp_ff.wready <= !w_got_ff && !(axi_req.wvalid && rsp_ff.wready);
            if (axi_req.awvalid && rsp_ff.awready) begin
                aw_got_ff <= 1'b1;
                aw_addr_ff <= axi_req.awaddr;
            end
            if (axi_req.wvalid && rsp_ff.wready) begin
                w_got_ff <= 1'b1;
                w_data_ff <= axi_req.wdata;
                w_strb0_ff <= axi_req.wstrb[0];
            end
            if (do_write) begin
                rsp_ff.bvalid <= 1'b1;
                rsp_ff.bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rsp_ff.bvalid && axi_req.bready) begin
                rsp_ff.bvalid <= 1'b0;
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                rsp_ff.awready <= 1'b1;
                rsp_ff.wready <= 1'b1;
            end
            if (axi_req.arvalid && rsp_ff.arready) begin
                rsp_ff.arready <= 1'b0;
                rsp_ff.rvalid <= 1'b1;
                rsp_ff.rdata <= rd_hit ? rd_word : 32'h00000000;
                rsp_ff.rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rsp_ff.rvalid && axi_req.rready) begin
                rsp_ff.rvalid <= 1'b0;
                rsp_ff.arready <= 1'b1;
            end else if (!rsp_ff.rvalid) begin
                rsp_ff.arready <= 1'b1;
            end
        end
    end

    // Read data mux
    always_comb begin
        rd_word = 32'h00000000;
        case (axi_req.araddr)
            GEAR_CTRL_OFF: begin
                rd_word[DVS_LSB +: 3] = divider_speed_sel_ff;
                rd_word[GEAR_LSB +: 2] = gear_req_ff;
            end
            TBASE_CTRL_OFF: rd_word[SEVEN_BIT] = seventh_stage_sel_ff;
            MODE_CTRL_OFF: begin
                rd_word[MODE_DUAL_BIT] = dual_ff;
                rd_word[MODE_SLOW_BIT] = system_clock_source_sel_ff;
                rd_word[MODE_STOP_BIT] = stop_ff;
            end
            STATUS_OFF: begin
                rd_word[ST_GEAR_LSB +: 2] = gear_cur;
                rd_word[ST_STATE_LSB +: 2] = mc_state;
                rd_word[ST_INDEX_LSB +: 4] = mc_index;
                rd_word[ST_TAP_LSB +: 4] = tap_ok_ff;
            end
            default: rd_word = 32'h00000000;
        endcase
    end

    // (R07) (R18) gear control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            divider_speed_sel_ff <= DVS_RST;
            gear_req_ff <= GEAR_RST;
        end else if (do_write && w_strb0_ff && aw_addr_ff == GEAR_CTRL_OFF) begin
            divider_speed_sel_ff <= w_data_ff[DVS_LSB +: 3];
            gear_req_ff <= w_data_ff[GEAR_LSB +: 2];
        end
    end

    // Time base and mode registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seventh_stage_sel_ff <= 1'b0;
            dual_ff <= 1'b0;
            system_clock_source_sel_ff <= 1'b0;
        end else if (do_write && w_strb0_ff) begin
            if (aw_addr_ff == TBASE_CTRL_OFF) begin
                seventh_stage_sel_ff <= w_data_ff[SEVEN_BIT];
            end
            if (aw_addr_ff == MODE_CTRL_OFF) begin
                dual_ff <= w_data_ff[MODE_DUAL_BIT];
                system_clock_source_sel_ff <= w_data_ff[MODE_SLOW_BIT];
            end
        end
    end

    // Stop mode: software enters, release pin leaves
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_ff <= 1'b0;
            stop_d_ff <= 1'b0;
        end else begin
            stop_d_ff <= stop_ff;
            if (do_write && w_strb0_ff && aw_addr_ff == MODE_CTRL_OFF
                && w_data_ff[MODE_STOP_BIT]) begin
                stop_ff <= 1'b1;
            end else if (rel_s2_ff) begin
                stop_ff <= 1'b0;
            end
        end
    end

    // (R10) clear on stop entry and exit
    assign clr = stop_ff != stop_d_ff;
    // (R11) low clock feeds stage seven when selected
    assign use_fs = system_clock_source_sel_ff || (dual_ff && seventh_stage_sel_ff);
    // (R13) stages one to six halt in slow modes
    assign low_run = pre_ff == PRE_WRAP && !system_clock_source_sel_ff && !stop_ff;
    assign seven_in = use_fs ? lf_edge && !stop_ff
        : low_run && &div_ff[LOW_STAGES-1:0];

    // (R04) (R06) timing prescaler runs on fast clock
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            pre_ff <= 2'h0;
        end else begin
            pre_ff <= pre_ff + 2'h1;
        end
    end

    // (R17) each divider stage halves the last
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            div_ff <= '0;
        end else begin
            if (low_run) begin
                div_ff[LOW_STAGES-1:0] <= div_ff[LOW_STAGES-1:0] + 6'h01;
            end
            if (seven_in) begin
                div_ff[DIV_STAGES-1:LOW_STAGES] <= div_ff[DIV_STAGES-1:LOW_STAGES] + 15'h0001;
            end
        end
    end

    // (R07) taps from high or low speed stages
    assign shift = tap_shift(divider_speed_sel_ff);
    generate
        for (genvar i = 0; i < 4; i++) begin : g_tap
            assign nxt_taps[i] = div_ff[i + 32'(shift)];
        end
    endgenerate

    // (R16) main clock from gear or low clock
    assign main_tick = stop_ff ? 1'b0 : system_clock_source_sel_ff ? lf_edge : gear_tick;

    // (R05) (R08) registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            taps_ff <= 4'h0;
            tap_ok_ff <= 4'h0;
            main_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            taps_ff <= nxt_taps;
            tap_ok_ff <= tap_avail(divider_speed_sel_ff, gear_cur);
            main_ff <= main_tick;
            pulse_ff <= div_ff[DIV_STAGES-1];
        end
    end

    assign axi_rsp = rsp_ff;
    assign main_system_clock = main_ff;
    assign div_stages = div_ff;
    assign div_taps = taps_ff;
    assign tap_usable = tap_ok_ff;
    assign divider_pulse_output = pulse_ff;

    a_stop_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        clr |=> div_ff == '0 && pre_ff == 2'h0)
        else $error("chain not cleared at stop edge");
    a_low_frozen: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        system_clock_source_sel_ff && !clr |=> $stable(div_ff[LOW_STAGES-1:0]))
        else $error("low stages ran in slow mode");
    a_seven_low: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        use_fs && lf_edge && !stop_ff && !clr |=> div_ff[DIV_STAGES-1:LOW_STAGES]
        == 15'($past(div_ff[DIV_STAGES-1:LOW_STAGES]) + 15'h0001))
        else $error("stage seven missed low clock edge");
    a_pre_free: assert property (@(posedge aclk) disable iff (!aresetn) // R06
        aresetn && !clr |=> pre_ff == 2'($past(pre_ff) + 2'h1))
        else $error("prescaler depends on gear");
    a_main_slow: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        system_clock_source_sel_ff && !stop_ff && lf_edge |=> main_system_clock)
        else $error("main clock missed low clock in slow mode");
    a_tap_eighth: assert property (@(posedge aclk) disable iff (!aresetn) // R08
        gear_cur == 2'h3 |=> tap_usable == 4'h0)
        else $error("tap usable at eighth gear");
    a_speed_reset: assert property (@(posedge aclk) // R18
        $rose(aresetn) |-> divider_speed_sel_ff == DVS_RST)
        else $error("speed field not reset");
    a_stop_halt: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        stop_ff |=> !main_system_clock)
        else $error("main clock ran during stop");
endmodule

// [dv/test_scg_system_clock_gear_timing.sv]
// Self-checking testbench for the system clock gear and timing block
`timescale 1ns/1ps
module test_scg_system_clock_gear_timing import scg_pkg::*;;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    scg_axi_req_t req = '0;
    scg_axi_rsp_t rsp;
    logic low_freq_clock = 1'b0;
    logic stop_release = 1'b0;
    logic [3:0] instr_len = 4'h1;
    logic main_system_clock;
    logic [1:0] mc_state;
    logic [3:0] mc_index;
    logic instr_end;
    logic [DIV_STAGES-1:0] div_stages;
    logic [3:0] div_taps;
    logic [3:0] tap_usable;
    logic divider_pulse_output;
    int error_cnt = 0;
    int checked = 0;
    int lf_cnt = 0;

    scg_system_clock_gear_timing scg_system_clock_gear_timing_inst (
        .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .low_freq_clock(low_freq_clock), .stop_release(stop_release),
        .instr_len(instr_len), .main_system_clock(main_system_clock),
        .mc_state(mc_state), .mc_index(mc_index), .instr_end(instr_end),
        .div_stages(div_stages), .div_taps(div_taps), .tap_usable(tap_usable),
        .divider_pulse_output(divider_pulse_output)
    );

    // Clock at 250 MHz
    always #2 aclk = ~aclk;

    // Slow clock pin, period of 40 fast cycles
    always @(posedge aclk) begin
        lf_cnt <= (lf_cnt == 19) ? 0 : lf_cnt + 1;
        if (lf_cnt == 19) begin
            low_freq_clock <= ~low_freq_clock;
        end
    end

    // Compare one value and count it
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        begin
            checked++;
            if (seen !== exp) begin
                error_cnt++;
                $display("ERROR %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    // Verdict and end of run
    task complete_run();
        begin
            $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0) begin
                $display("DONE - PASS");
            end else begin
                $display("DONE - FAIL");
            end
            $finish;
        end
    endtask

    // Bus write, address and data offered together
    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        begin
            n = 0;
            resp = 2'h1;
            @(posedge aclk);
            req.awvalid <= 1'b1;
            req.awaddr <= a;
            req.wvalid <= 1'b1;
            req.wdata <= d;
            req.wstrb <= 4'hf;
            req.bready <= 1'b1;
            while (n < 200) begin
                @(posedge aclk);
                n++;
                if (req.awvalid && rsp.awready === 1'b1) begin
                    req.awvalid <= 1'b0;
                end
                if (req.wvalid && rsp.wready === 1'b1) begin
                    req.wvalid <= 1'b0;
                end
                if (rsp.bvalid === 1'b1) begin
                    resp = rsp.bresp;
                    req.bready <= 1'b0;
                    break;
                end
            end
            if (n >= 200) begin
                check("write answer", 32'h0, 32'h1);
            end
        end
    endtask

    // Bus read, ready held until data comes
    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        begin
            n = 0;
            d = '1;
            resp = 2'h1;
            @(posedge aclk);
            req.arvalid <= 1'b1;
            req.araddr <= a;
            req.rready <= 1'b1;
            while (n < 200) begin
                @(posedge aclk);
                n++;
                if (req.arvalid && rsp.arready === 1'b1) begin
                    req.arvalid <= 1'b0;
                end
                if (rsp.rvalid === 1'b1) begin
                    d = rsp.rdata;
                    resp = rsp.rresp;
                    req.rready <= 1'b0;
                    break;
                end
            end
            if (n >= 200) begin
                check("read answer", 32'h0, 32'h1);
            end
        end
    endtask

    function automatic logic pick(input int sel);
        return (sel == 0) ? instr_end : div_stages[0];
    endfunction

    // Cycles between two rising edges of the picked signal
    task gap(input int sel, output int cyc);
        int n;
        logic prev;
        logic cur;
        begin
            prev = 1'b1;
            cur = 1'b0;
            cyc = 0;
            n = 0;
            while (n < 2000) begin
                @(posedge aclk);
                n++;
                cur = pick(sel);
                if (cur && !prev) break;
                prev = cur;
            end
            prev = 1'b1;
            while (n < 4000) begin
                @(posedge aclk);
                n++;
                cyc++;
                cur = pick(sel);
                if (cur && !prev) break;
                prev = cur;
            end
        end
    endtask

    // Defaults after reset and bus refusals
    task t_reset_and_bus();
        logic [31:0] d;
        logic [1:0] r;
        begin
            axi_read(GEAR_CTRL_OFF, d, r);
            check("gear ctrl reset", d, 32'h3);
            axi_read(TBASE_CTRL_OFF, d, r);
            check("tbase reset", d, 32'h0);
            axi_read(8'h10, d, r);
            check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
            check("unmapped data", d, 32'h0);
            axi_write(STATUS_OFF, 32'h0, r);
            check("status write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
            // seventh select only in dual mode
            axi_write(MODE_CTRL_OFF, 32'h1, r);
            axi_write(TBASE_CTRL_OFF, 32'h10, r);
            axi_read(TBASE_CTRL_OFF, d, r);
            check("seventh select", d, 32'h10);
            axi_write(TBASE_CTRL_OFF, 32'h0, r);
            axi_write(MODE_CTRL_OFF, 32'h0, r);
        end
    endtask

    // Gear sweep: main clock follows gear, divider taps do not
    task t_gear_sweep();
        logic [1:0] r;
        int cyc;
        int base;
        logic [31:0] d;
        begin
            instr_len <= 4'h1;
            gap(1, base);
            gap(1, base);
            for (int g = 0; g < 4; g++) begin
                axi_write(GEAR_CTRL_OFF, g, r);
                gap(0, cyc);
                gap(0, cyc);
                check("machine cycle length", cyc, 4 << g);
                gap(1, cyc);
                check("stage one period", cyc, base);
                axi_read(STATUS_OFF, d, r);
                check("status gear", d & 32'h3, g);
            end
        end
    endtask

    // Instruction lengths at full gear, with clamping
    task t_instr_len();
        logic [1:0] r;
        int cyc;
        logic [3:0] lens [4] = '{4'h1, 4'ha, 4'h0, 4'hf};
        int exp [4] = '{1, 10, 1, 10};
        begin
            axi_write(GEAR_CTRL_OFF, 32'h0, r);
            for (int i = 0; i < 4; i++) begin
                instr_len <= lens[i];
                gap(0, cyc);
                gap(0, cyc);
                check("instruction length", cyc, 4 * exp[i]);
            end
            instr_len <= 4'h1;
        end
    endtask

    // Tap availability for speed codes 100 and 110
    task t_taps();
        logic [1:0] r;
        logic [3:0] e100 [4] = '{4'hf, 4'hf, 4'h8, 4'h0};
        logic [3:0] e110 [4] = '{4'hf, 4'hf, 4'hf, 4'h0};
        logic [3:0] low;
        begin
            // no tap user runs while speed changes
            for (int g = 0; g < 4; g++) begin
                axi_write(GEAR_CTRL_OFF, 32'h80 | g, r);
                repeat (12) @(posedge aclk);
                check("taps code 100", {28'h0, tap_usable}, {28'h0, e100[g]});
                axi_write(GEAR_CTRL_OFF, 32'hc0 | g, r);
                repeat (12) @(posedge aclk);
                check("taps code 110", {28'h0, tap_usable}, {28'h0, e110[g]});
                low = div_stages[5:2];
                @(posedge aclk);
                check("low speed taps", {28'h0, div_taps}, {28'h0, low});
            end
            axi_write(GEAR_CTRL_OFF, 32'h0, r);
        end
    endtask

    // Slow mode: low stages stop, main clock from slow pin
    task t_slow();
        logic [1:0] r;
        logic [5:0] low;
        int cyc;
        begin
            axi_write(MODE_CTRL_OFF, 32'h3, r);
            repeat (20) @(posedge aclk);
            low = div_stages[5:0];
            repeat (200) @(posedge aclk);
            check("low stages held", {26'h0, div_stages[5:0]}, {26'h0, low});
            gap(0, cyc);
            gap(0, cyc);
            check("slow machine cycle", cyc, 160);
            axi_write(MODE_CTRL_OFF, 32'h0, r);
        end
    endtask

    // Stop entry clears the chain, release pin leaves stop
    task t_stop();
        logic [1:0] r;
        logic [31:0] d;
        begin
            repeat (50) @(posedge aclk);
            axi_write(MODE_CTRL_OFF, 32'h4, r);
            repeat (10) @(posedge aclk);
            check("divider cleared on stop", {11'h0, div_stages}, 32'h0);
            axi_read(MODE_CTRL_OFF, d, r);
            check("stop state", d & 32'h4, 32'h4);
            stop_release <= 1'b1;
            repeat (4) @(posedge aclk);
            stop_release <= 1'b0;
            repeat (3) @(posedge aclk);
            check("divider cleared on release", {11'h0, div_stages} & 32'h1ffff0, 32'h0);
            @(posedge aclk);
            check("release phase", {31'h0, div_stages[0]}, 32'h0);
            @(posedge aclk);
            check("release first count", {31'h0, div_stages[0]}, 32'h1);
            axi_read(MODE_CTRL_OFF, d, r);
            check("stop left", d & 32'h4, 32'h0);
        end
    endtask

    // Watchdog
    initial begin
        repeat (60000) @(posedge aclk);
        error_cnt++;
        $display("ERROR watchdog expected finish seen hang");
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_and_bus();
        t_gear_sweep();
        t_instr_len();
        t_taps();
        t_slow();
        t_stop();
        complete_run();
    end
endmodule
